// ===== rtl/clk_stop_pkg.sv
package clk_stop_pkg;

  // Value after reset of the synchroniser stages (request idle high)
  localparam logic SYNC_RESET_VAL = 1'b1;
  // Value after reset of the trip latch
  localparam logic TRIP_RESET_VAL = 1'b0;
  // Nominal trip level, for reference only; the sensor compares internally
  localparam int TRIP_LEVEL_DEGC = 135;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ACK = 2'b01,
    ST_HALT = 2'b10,
    ST_RESUME = 2'b11
  } pm_state_t;

  // Value after reset of the stop-grant sequencer
  localparam pm_state_t STATE_RESET_VAL = ST_RUN;
  // Value after reset of the interrupt, service and snoop flags
  localparam logic FLAG_RESET_VAL = 1'b0;
  // Values after reset of the registered status outputs
  localparam logic ACK_RESET_VAL = 1'b0;
  localparam logic CORE_EN_RESET_VAL = 1'b1;
  localparam logic EXEC_RESET_VAL = 1'b1;

endpackage

// ===== rtl/core_clock_stop_thermal_trip.sv
// Function
// (RULE1) Active halt request enters halt-grant state
// (RULE2) Issue acknowledge transaction on entering halt-grant
// (RULE3) Gate core clocks, keep bus and interrupt
// (RULE4) Keep snooping, capture interrupts while halted
// (RULE5) On release, restart clocks, resume, service interrupts
// (RULE6) Bus clock untouched; only core clocks gated
// (RULE7) Halt request is asynchronous to bus clock
// (RULE8) Two-stage synchroniser before state machine
// (RULE9) Over-temperature halts execution, asserts trip
// (RULE10) Trip and halt latched until reset
// (RULE11) No hysteresis; cool reset clears trip
// (RULE12) Still hot after reset re-trips
// (RULE13) System ignores trip output during reset
// (RULE14) Trip output active low, cleared by reset
module core_clock_stop_thermal_trip
  import clk_stop_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic halt_request_n,
  input wire logic over_temp,
  input wire logic irq_in,
  input wire logic snoop_req,
  input wire logic ack_done,
  output logic ack_req,
  output logic core_clk_en,
  output logic bus_clk_en,
  output logic local_irq_ctrl_clk_en,
  output logic snoop_resp,
  output logic exec_en,
  output logic irq_pending,
  output logic irq_service,
  output logic overheat_trip_n
);

  logic req_meta_q;
  logic req_sync_q;
  logic req_meta_d;
  logic req_sync_d;
  pm_state_t state_q;
  pm_state_t state_d;
  logic trip_q;
  logic trip_d;
  logic irq_q;
  logic irq_d;
  logic snoop_q;
  logic snoop_d;
  logic irq_svc_q;
  logic irq_svc_d;
  // Registered status outputs and their next values
  logic ack_req_q;
  logic ack_req_d;
  logic core_en_q;
  logic core_en_d;
  logic run_d;
  logic exec_q;
  logic exec_d;
  logic trip_n_q;
  logic trip_n_d;

  // Synchroniser next values; first stage feeds only the second
  always_comb begin
    req_meta_d = halt_request_n; // [RULE7]
    req_sync_d = req_meta_q; // [RULE8]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_meta_q <= SYNC_RESET_VAL;
      req_sync_q <= SYNC_RESET_VAL;
    end else begin
      req_meta_q <= req_meta_d;
      req_sync_q <= req_sync_d;
    end
  end

  // Trip latch; sensor is sampled fresh after each reset, no hysteresis
  always_comb begin
    trip_d = trip_q | over_temp; // [RULE9] [RULE10] [RULE12]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trip_q <= TRIP_RESET_VAL; // [RULE11] [RULE14]
    end else begin
      trip_q <= trip_d;
    end
  end

  // Stop-grant sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (!req_sync_q) begin
          state_d = ST_ACK; // [RULE1]
        end
      end
      ST_ACK: begin
        // Acknowledge must complete before core clocks stop
        if (ack_done) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (req_sync_q) begin
          state_d = ST_RESUME; // [RULE5]
        end
      end
      ST_RESUME: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= STATE_RESET_VAL;
    end else begin
      state_q <= state_d;
    end
  end

  // Interrupt capture on the ungated clock, so none is missed while halted
  always_comb begin
    irq_svc_d = 1'b0;
    irq_d = irq_q;
    // Service only once running again and not tripped
    if (state_q == ST_RUN && irq_q && !trip_q) begin
      irq_svc_d = 1'b1; // [RULE5]
      irq_d = 1'b0;
    end
    // New interrupt wins over the service clear so none is lost
    if (irq_in) begin
      irq_d = 1'b1; // [RULE4]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_q <= FLAG_RESET_VAL;
      irq_svc_q <= FLAG_RESET_VAL;
    end else begin
      irq_q <= irq_d;
      irq_svc_q <= irq_svc_d;
    end
  end

  // Snoop answer, one cycle late in every state including halt
  always_comb begin
    snoop_d = snoop_req; // [RULE4]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      snoop_q <= FLAG_RESET_VAL;
    end else begin
      snoop_q <= snoop_d;
    end
  end

  // Status decoded from the next state, so the registered copies
  // move on the same edge as the state and add no latency
  always_comb begin
    ack_req_d = 1'b0;
    core_en_d = 1'b1;
    run_d = 1'b0;
    case (state_d)
      ST_RUN: begin
        run_d = 1'b1; // [RULE5]
      end
      ST_ACK: begin
        ack_req_d = 1'b1; // [RULE2]
      end
      ST_HALT: begin
        core_en_d = 1'b0; // [RULE3]
      end
      ST_RESUME: begin
        core_en_d = 1'b1; // [RULE5]
      end
      default: begin
        core_en_d = 1'b1;
      end
    endcase
    // Latched trip overrides the sequencer; execution stays stopped
    exec_d = run_d && !trip_d; // [RULE9] [RULE10]
    trip_n_d = ~trip_d; // [RULE14]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_req_q <= ACK_RESET_VAL;
      core_en_q <= CORE_EN_RESET_VAL;
      exec_q <= EXEC_RESET_VAL;
      trip_n_q <= ~TRIP_RESET_VAL; // [RULE14]
    end else begin
      ack_req_q <= ack_req_d;
      core_en_q <= core_en_d;
      exec_q <= exec_d;
      trip_n_q <= trip_n_d;
    end
  end

  // Outputs; bus and interrupt clock enables never drop
  assign ack_req = ack_req_q; // [RULE2]
  assign core_clk_en = core_en_q; // [RULE3]
  assign bus_clk_en = 1'b1; // [RULE3] [RULE6]
  assign local_irq_ctrl_clk_en = 1'b1; // [RULE3]
  assign snoop_resp = snoop_q;
  assign exec_en = exec_q; // [RULE9] [RULE10]
  assign irq_pending = irq_q;
  assign irq_service = irq_svc_q;
  assign overheat_trip_n = trip_n_q; // [RULE14]

endmodule // core_clock_stop_thermal_trip

// ===== test/chipset_model.sv
module chipset_model (
  input wire logic core_clk,
  input wire logic ack_req,
  input wire logic stop,
  output logic halt_request_n = 1'h1,
  output logic ack_done = 1'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  // Skewed off the bus clock so sync is exercised
  always @(stop) halt_request_n <= #7 !stop;
  // Finish the acknowledge one cycle after it starts
  always @(posedge core_clk) ack_done <= ack_req && !ack_done;
endmodule // chipset_model

// ===== test/clk_stop_sva.sv
module clk_stop_sva (
  input wire logic core_clk,
  rst,
  halt_request_n,
  over_temp,
  snoop_req,
  ack_done,
  ack_req,
  core_clk_en,
  snoop_resp,
  exec_en,
  overheat_trip_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Request must pass both stages first
  a_sync_delay: assert property ($fell(halt_request_n) && exec_en |=> !ack_req [*2])
    else $error("early ack");
  a_halt_entry: assert property ($fell(halt_request_n) && exec_en ##1 !halt_request_n [*3] |-> ack_req && !exec_en)
    else $error("no ack");
  a_ack_stand: assert property (ack_req && !ack_done |=> ack_req)
    else $error("ack dropped");
  a_gate_core: assert property (ack_req && ack_done |=> !ack_req && !core_clk_en)
    else $error("no gate");
  a_snoop_live: assert property (!$past(rst) |-> snoop_resp == $past(snoop_req))
    else $error("snoop");
  a_resume_run: assert property ($rose(halt_request_n) && !core_clk_en ##1 halt_request_n [*2] |=> core_clk_en ##1 exec_en)
    else $error("no resume");
  a_trip_set: assert property (over_temp |=> !overheat_trip_n && !exec_en)
    else $error("no trip");
  a_trip_latch: assert property (!overheat_trip_n |=> !overheat_trip_n)
    else $error("trip lost");
endmodule // clk_stop_sva

bind core_clock_stop_thermal_trip clk_stop_sva sva (
  .core_clk(core_clk),
  .rst(rst),
  .halt_request_n(halt_request_n),
  .over_temp(over_temp),
  .snoop_req(snoop_req),
  .ack_done(ack_done),
  .ack_req(ack_req),
  .core_clk_en(core_clk_en),
  .snoop_resp(snoop_resp),
  .exec_en(exec_en),
  .overheat_trip_n(overheat_trip_n)
);

// ===== test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'h0, rst = 1'h1, stop = 1'h0, over_temp = 1'h0, irq_in = 1'h0, snoop_req = 1'h0;
  logic halt_request_n, ack_done, ack_req, core_clk_en, bus_clk_en, local_irq_ctrl_clk_en;
  logic snoop_resp, exec_en, irq_pending, irq_service, overheat_trip_n;
  int fail_count = 0, n_checks = 0, cyc = 0;
  chipset_model sys (
    .core_clk(core_clk),
    .ack_req(ack_req),
    .stop(stop),
    .halt_request_n(halt_request_n),
    .ack_done(ack_done)
  );
  core_clock_stop_thermal_trip dut (
    .core_clk(core_clk),
    .rst(rst),
    .halt_request_n(halt_request_n),
    .over_temp(over_temp),
    .irq_in(irq_in),
    .snoop_req(snoop_req),
    .ack_done(ack_done),
    .ack_req(ack_req),
    .core_clk_en(core_clk_en),
    .bus_clk_en(bus_clk_en),
    .local_irq_ctrl_clk_en(local_irq_ctrl_clk_en),
    .snoop_resp(snoop_resp),
    .exec_en(exec_en),
    .irq_pending(irq_pending),
    .irq_service(irq_service),
    .overheat_trip_n(overheat_trip_n)
  );
  // 25 ns bus clock
  initial forever #12.5 core_clk = ~core_clk;
  // Hang guard, far above the expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 500) begin
      fail_count++;
      conclude();
    end
  end
  // Inputs move just after the edge
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task chk(input logic a, input logic e);
    n_checks++;
    if (a !== e) begin
      fail_count++;
      $display("unexpected %0t got %h exp %h", $time, a, e);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Enter halt, snoop and interrupt while gated, resume
  task t_halt;
    stop = 1'h1;
    step(2); chk(ack_req, 1'h0);
    step(1); chk(ack_req, 1'h1);
    chk(exec_en, 1'h0);
    step(2); chk(core_clk_en, 1'h0);
    chk(bus_clk_en, 1'h1);
    chk(local_irq_ctrl_clk_en, 1'h1);
    irq_in = 1'h1;
    snoop_req = 1'h1;
    step(1); chk(snoop_resp, 1'h1);
    chk(irq_pending, 1'h1);
    {irq_in, snoop_req, stop} = 3'h0;
    step(3); chk(core_clk_en, 1'h1);
    step(1); chk(exec_en, 1'h1);
    step(1); chk(irq_service, 1'h1);
    $display("halt test done");
  endtask
  // Trip, latch, cool reset, hot reset
  task t_trip;
    over_temp = 1'h1;
    step(1); chk(overheat_trip_n, 1'h0);
    over_temp = 1'h0;
    step(4); chk(overheat_trip_n, 1'h0);
    chk(exec_en, 1'h0);
    rst = 1'h1;
    step(1); rst = 1'h0;
    step(1); chk(overheat_trip_n, 1'h1);
    chk(exec_en, 1'h1);
    {rst, over_temp} = 2'h3;
    step(1); rst = 1'h0;
    step(2); chk(overheat_trip_n, 1'h0);
    chk(exec_en, 1'h0);
    $display("trip test done");
  endtask
  initial begin
    step(8);
    rst = 1'h0;
    step(1);
    t_halt;
    t_trip;
    conclude;
  end
endmodule // testbench
